/* File: core/wiper_cmd_decoder.sv */
// Dual wiper command decoder: serial link front end and command engine.
// Assumes the host drives chip select and serial clock (mode 0, rising
// edge sampling) and leaves chip select high for a few core cycles
// between words.

`timescale 1ns/10ps
`default_nettype none

module wiper_cmd_decoder
    import wiper_cmd_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       SYS_RST_I,
    input  wire logic       SERIAL_CLK_I,
    input  wire logic       CHIP_SELECT_N_I,
    input  wire logic       SERIAL_INPUT_PIN_I,
    output logic            SERIAL_OUTPUT_PIN_O,
    output logic            SERIAL_OUTPUT_PIN_OE_O,
    input  wire logic       PRESET_RELOAD_PIN_N_I,
    output logic [7:0]      WIPER0_O,
    output logic [7:0]      WIPER1_O,
    output logic            READ_POWER_STATE_O
);

    // Link domain state
    logic [15:0]            link_sreg_ff;
    logic [4:0]             link_cnt_ff;
    logic                   link_got_ff;
    logic                   serial_out_bit;

    // Core domain synchronisers and levels
    logic [2:0]             cs_sync_ff;
    logic                   cs_level_ff;
    logic                   cs_rise;
    logic [2:0]             preset_sync_ff;
    logic                   preset_level_ff;
    logic                   preset_rise;
    logic [2:0]             got_sync_ff;
    logic                   got_level_ff;

    // Command engine
    exec_state_type         state_ff;
    exec_state_type         nxt_state;
    word_type               link_word;
    word_type               cmd_word_ff;
    logic                   cmd_valid_ff;
    word_type               rep_word_ff;
    logic                   rep_valid_ff;
    logic                   got_clr_ff;
    logic                   exec;
    logic                   wiper_select_bit;
    logic                   read_power_ff;
    logic [7:0]             rb_byte_ff;
    logic                   rb_active_ff;
    logic [7:0]             nv_ff [NV_ENTRIES];
    logic [7:0]             wiper_now [WIPER_COUNT];

    // Step and shift arithmetic; every result stays in 0..255
    function automatic logic [7:0] step_value(input logic [3:0] op,
                                              input logic [7:0] w);
        logic [7:0] r;
        r = w;
        unique case (op)
            OP_HALVE_ONE, OP_HALVE_ALL:
                r = {1'b0, w[7:1]};
            OP_DEC_ONE, OP_DEC_ALL:
                r = (w == WIPER_ZERO) ? WIPER_ZERO
                                      : w - WIPER_ONE;
            OP_DOUBLE_ONE, OP_DOUBLE_ALL: begin
                if (w == WIPER_ZERO) begin
                    r = WIPER_ONE;
                end else if (w >= WIPER_MIDSCALE) begin
                    r = WIPER_FULL;
                end else begin
                    r = {w[6:0], 1'b0};
                end
            end
            OP_INC_ONE, OP_INC_ALL:
                r = (w == WIPER_FULL) ? WIPER_FULL
                                      : w + WIPER_ONE;
            default:
                r = w;
        endcase
        return r;
    endfunction

    // Repeatable commands are the step and shift group
    function automatic logic is_step(input logic [3:0] op);
        return (op == OP_HALVE_ONE) || (op == OP_HALVE_ALL) ||
               (op == OP_DEC_ONE)   || (op == OP_DEC_ALL)   ||
               (op == OP_DOUBLE_ONE) || (op == OP_DOUBLE_ALL) ||
               (op == OP_INC_ONE)   || (op == OP_INC_ALL);
    endfunction

    // Serial shift register, MSB first; keeps only the last 16 bits so
    // longer frames pass through for daisy chaining
    always_ff @(posedge SERIAL_CLK_I) begin
        link_sreg_ff <= {link_sreg_ff[14:0], SERIAL_INPUT_PIN_I};
    end

    // Bit position inside the frame; cleared while chip select is high,
    // since the link clock may stop between frames
    always_ff @(posedge SERIAL_CLK_I or posedge CHIP_SELECT_N_I) begin
        if (CHIP_SELECT_N_I) begin
            link_cnt_ff <= 5'h00;
        end else if (link_cnt_ff != WORD_BIT_COUNT) begin
            link_cnt_ff <= link_cnt_ff + 5'h01;
        end
    end

    // Marks that the frame carried bits; the core clears it once the
    // word is taken, so a bare strobe can be told from a new word
    always_ff @(posedge SERIAL_CLK_I or posedge got_clr_ff) begin
        if (got_clr_ff) begin
            link_got_ff <= 1'b0;
        end else begin
            link_got_ff <= 1'b1;
        end
    end

    // Serial output: chained bits, or the readback byte once the
    // instruction half of the old word has left
    always_comb begin
        serial_out_bit = link_sreg_ff[15];
        if (rb_active_ff && (link_cnt_ff >= READBACK_FIRST_BIT) &&
            (link_cnt_ff < WORD_BIT_COUNT)) begin
            serial_out_bit = rb_byte_ff[~link_cnt_ff[2:0]];
        end
    end

    // Open drain: pull low only for a zero, released while deselected
    assign SERIAL_OUTPUT_PIN_O    = 1'b0;
    assign SERIAL_OUTPUT_PIN_OE_O = ~CHIP_SELECT_N_I & ~serial_out_bit;

    // Chip select synchroniser; a change counts when stages 2 and 3 agree
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            cs_sync_ff  <= 3'h7;
            cs_level_ff <= 1'b1;
        end else begin
            cs_sync_ff <= {cs_sync_ff[1:0], CHIP_SELECT_N_I};
            if (cs_sync_ff[1] == cs_sync_ff[2]) begin
                cs_level_ff <= cs_sync_ff[2];
            end
        end
    end

    assign cs_rise = ~cs_level_ff & cs_sync_ff[2] &
                     (cs_sync_ff[1] == cs_sync_ff[2]);

    // Preset pin synchroniser, same filtering
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            preset_sync_ff  <= 3'h7;
            preset_level_ff <= 1'b1;
        end else begin
            preset_sync_ff <= {preset_sync_ff[1:0], PRESET_RELOAD_PIN_N_I};
            if (preset_sync_ff[1] == preset_sync_ff[2]) begin
                preset_level_ff <= preset_sync_ff[2];
            end
        end
    end

    assign preset_rise = ~preset_level_ff & preset_sync_ff[2] &
                         (preset_sync_ff[1] == preset_sync_ff[2]);

    // Frame flag synchroniser
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            got_sync_ff  <= 3'h0;
            got_level_ff <= 1'b0;
        end else begin
            got_sync_ff <= {got_sync_ff[1:0], link_got_ff};
            if (got_sync_ff[1] == got_sync_ff[2]) begin
                got_level_ff <= got_sync_ff[2];
            end
        end
    end

    // The shift register is quiet while chip select is high, and it is
    // only read after the filtered rising edge, so it is stable here
    assign link_word = word_type'(link_sreg_ff);

    // Sequencer: take the word, execute it, then clear the frame flag
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:    if (cs_rise) nxt_state = ST_EXEC;
            ST_EXEC:    nxt_state = ST_RELEASE;
            ST_RELEASE: if (!got_level_ff) nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Flag clear drives an asynchronous clear, so it comes from a flop
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            got_clr_ff <= 1'b1;
        end else begin
            got_clr_ff <= (nxt_state == ST_RELEASE);
        end
    end

    // Pick the new word, or on a bare strobe replay the last word if it was a step command
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            cmd_word_ff  <= word_type'(16'h0000);
            cmd_valid_ff <= 1'b0;
            rep_word_ff  <= word_type'(16'h0000);
            rep_valid_ff <= 1'b0;
        end else if (state_ff == ST_IDLE && cs_rise) begin
            if (got_level_ff) begin
                cmd_word_ff  <= link_word;
                cmd_valid_ff <= 1'b1;
                rep_word_ff  <= link_word;
                rep_valid_ff <= is_step(link_word.opcode);
            end else begin
                cmd_word_ff  <= rep_word_ff;
                cmd_valid_ff <= rep_valid_ff;
            end
        end
    end

    assign exec = (state_ff == ST_EXEC) && cmd_valid_ff;
    assign wiper_select_bit = cmd_word_ff.addr[0];

    // Nonvolatile store: presets at 0 and 1, user bytes above
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            for (int k = 0; k < NV_ENTRIES; k++) begin
                nv_ff[k] <= (k < WIPER_COUNT) ? NV_RESET_PRESET
                                              : NV_RESET_USER;
            end
        end else if (exec) begin
            if (cmd_word_ff.opcode == OP_SAVE_WIPER) begin
                nv_ff[wiper_select_bit ? NV_ADDR_WIPER1 : NV_ADDR_WIPER0]
                    <= wiper_now[wiper_select_bit];
            end else if (cmd_word_ff.opcode == OP_WRITE_NV) begin
                nv_ff[cmd_word_ff.addr] <= cmd_word_ff.data;
            end
        end
    end

    // One wiper per channel; preset pin outranks any serial command.
    // The reload edge is tested first: the filtered level is still low
    // in the cycle that carries the edge, and would otherwise mask it
    for (genvar i = 0; i < WIPER_COUNT; i++) begin : g_wiper
        logic [7:0] wiper_ff;
        logic       hit;
        logic [3:0] op;

        assign op  = cmd_word_ff.opcode;
        assign hit = (wiper_select_bit == 1'(i));

        always_ff @(posedge CORE_CLK_I) begin
            if (SYS_RST_I) begin
                wiper_ff <= NV_RESET_PRESET;
            end else if (preset_rise) begin
                wiper_ff <= nv_ff[i];
            end else if (!preset_level_ff) begin
                wiper_ff <= WIPER_MIDSCALE;
            end else if (exec) begin
                unique case (op)
                    OP_RESTORE_ONE:
                        if (hit) wiper_ff <= nv_ff[i];
                    OP_RESTORE_ALL:
                        wiper_ff <= nv_ff[i];
                    OP_WRITE_WIPER:
                        if (hit) wiper_ff <= cmd_word_ff.data;
                    OP_HALVE_ONE, OP_DEC_ONE, OP_DOUBLE_ONE, OP_INC_ONE:
                        if (hit) wiper_ff <= step_value(op, wiper_ff);
                    OP_HALVE_ALL, OP_DEC_ALL, OP_DOUBLE_ALL, OP_INC_ALL:
                        wiper_ff <= step_value(op, wiper_ff);
                    default:
                        wiper_ff <= wiper_ff;
                endcase
            end
        end

        assign wiper_now[i] = wiper_ff;
    end

    // Readback byte; stays put until the next executed command, which
    // is after the following frame has shifted it out
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            rb_byte_ff   <= WIPER_ZERO;
            rb_active_ff <= 1'b0;
        end else if (exec) begin
            if (cmd_word_ff.opcode == OP_READ_NV) begin
                rb_byte_ff   <= nv_ff[cmd_word_ff.addr];
                rb_active_ff <= 1'b1;
            end else if (cmd_word_ff.opcode == OP_READ_WIPER) begin
                rb_byte_ff   <= wiper_now[wiper_select_bit];
                rb_active_ff <= 1'b1;
            end else begin
                rb_active_ff <= 1'b0;
            end
        end
    end

    // Read power state: entered by a single-wiper restore, left only by a NOP or by reset
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            read_power_ff <= 1'b0;
        end else if (exec) begin
            if (cmd_word_ff.opcode == OP_RESTORE_ONE) begin
                read_power_ff <= 1'b1;
            end else if (cmd_word_ff.opcode == OP_NOP) begin
                read_power_ff <= 1'b0;
            end
        end
    end

    assign WIPER0_O           = wiper_now[0];
    assign WIPER1_O           = wiper_now[1];
    assign READ_POWER_STATE_O = read_power_ff;

endmodule

`default_nettype wire

/* File: core/wiper_cmd_pkg.sv */
// Shared constants and types for the dual wiper command decoder.
// Assumes a core clock of 40 MHz and a serial link with its own clock.
package wiper_cmd_pkg;

    // Serial word layout, most significant bit first
    localparam int WORD_BITS       = 16;
    localparam int OPCODE_MSB      = 15;
    localparam int OPCODE_LSB      = 12;
    localparam int ADDR_MSB        = 11;
    localparam int ADDR_LSB        = 8;
    localparam int DATA_MSB        = 7;
    localparam int DATA_LSB        = 0;

    // Bit count at which the data byte starts to leave the serial output
    localparam logic [4:0] READBACK_FIRST_BIT = 5'h08;
    localparam logic [4:0] WORD_BIT_COUNT     = 5'h10;

    // Opcodes
    localparam logic [3:0] OP_NOP          = 4'h0;
    localparam logic [3:0] OP_RESTORE_ONE  = 4'h1;
    localparam logic [3:0] OP_SAVE_WIPER   = 4'h2;
    localparam logic [3:0] OP_WRITE_NV     = 4'h3;
    localparam logic [3:0] OP_HALVE_ONE    = 4'h4;
    localparam logic [3:0] OP_HALVE_ALL    = 4'h5;
    localparam logic [3:0] OP_DEC_ONE      = 4'h6;
    localparam logic [3:0] OP_DEC_ALL      = 4'h7;
    localparam logic [3:0] OP_RESTORE_ALL  = 4'h8;
    localparam logic [3:0] OP_READ_NV      = 4'h9;
    localparam logic [3:0] OP_READ_WIPER   = 4'ha;
    localparam logic [3:0] OP_WRITE_WIPER  = 4'hb;
    localparam logic [3:0] OP_DOUBLE_ONE   = 4'hc;
    localparam logic [3:0] OP_DOUBLE_ALL   = 4'hd;
    localparam logic [3:0] OP_INC_ONE      = 4'he;
    localparam logic [3:0] OP_INC_ALL      = 4'hf;

    // Wiper codes
    localparam logic [7:0] WIPER_ZERO      = 8'h00;
    localparam logic [7:0] WIPER_ONE       = 8'h01;
    localparam logic [7:0] WIPER_MIDSCALE  = 8'h80;
    localparam logic [7:0] WIPER_FULL      = 8'hff;

    // Nonvolatile store map and reset contents
    localparam int         NV_ENTRIES      = 16;
    localparam int         WIPER_COUNT     = 2;
    localparam logic [3:0] NV_ADDR_WIPER0  = 4'h0;
    localparam logic [3:0] NV_ADDR_WIPER1  = 4'h1;
    localparam logic [7:0] NV_RESET_PRESET = 8'h80;
    localparam logic [7:0] NV_RESET_USER   = 8'h00;

    // One serial instruction word
    typedef struct packed {
        logic [3:0] opcode;
        logic [3:0] addr;
        logic [7:0] data;
    } word_type;

    // Command execution sequence in the core domain
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_EXEC,
        ST_RELEASE
    } exec_state_type;

endpackage

/* File: tb/host_link_model.sv */
// Host master of the serial link: chip select, link clock and data.
// Assumes the caller passes the pulled-up output pin level in.
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic level_i
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // Whole 16-bit word, MSB first; clock stands low outside frames
    task automatic frame(input logic [15:0] w, output logic [15:0] rx);
        #7;
        cs_n_o = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi_o = w[i];
            #24;
            rx[i] = level_i;  // Bit is valid before its rising edge
            sclk_o = 1'b1;
            #24;
            sclk_o = 1'b0;
        end
        #24;
        cs_n_o = 1'b1;
        mosi_o = ~mosi_o;  // Released data must not mimic held data
        #300;              // Twelve core cycles, above the minimum gap
    endtask

    // Chip-select pulse without link clock edges
    task automatic strobe();
        #7;
        cs_n_o = 1'b0;
        #100;
        cs_n_o = 1'b1;
        #300;
    endtask
endmodule
`default_nettype wire

/* File: tb/wiper_cmd_decoder_assertions.sv */
// Port checker for the dual wiper command decoder.
// Assumes the host leaves chip select high ten core cycles between words.
`timescale 1ns/10ps
`default_nettype none
module wiper_cmd_decoder_assertions
    import wiper_cmd_pkg::*;
(
    input wire logic       CORE_CLK_I,
    input wire logic       SYS_RST_I,
    input wire logic       SERIAL_CLK_I,
    input wire logic       CHIP_SELECT_N_I,
    input wire logic       SERIAL_INPUT_PIN_I,
    input wire logic       SERIAL_OUTPUT_PIN_O,
    input wire logic       SERIAL_OUTPUT_PIN_OE_O,
    input wire logic       PRESET_RELOAD_PIN_N_I,
    input wire logic [7:0] WIPER0_O,
    input wire logic [7:0] WIPER1_O,
    input wire logic       READ_POWER_STATE_O
);
    default clocking dclk @(posedge CORE_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    // Deselected device must let the pull-up own the line
    AST_SDO_RELEASED: assert property (CHIP_SELECT_N_I |->
        !SERIAL_OUTPUT_PIN_OE_O) else $error("output driven while idle");
    AST_SDO_OPEN_DRAIN: assert property (!SERIAL_OUTPUT_PIN_O)
        else $error("open drain value not low");
    // Reset stands for power-on, so wipers come from the factory store
    AST_RESET_MID: assert property (disable iff (1'b0)
        SYS_RST_I |=> WIPER0_O == NV_RESET_PRESET &&
        WIPER1_O == NV_RESET_PRESET && !READ_POWER_STATE_O)
        else $error("wipers wrong after reset");
    AST_PRESET_MID: assert property (!PRESET_RELOAD_PIN_N_I [*6] |->
        WIPER0_O == WIPER_MIDSCALE && WIPER1_O == WIPER_MIDSCALE)
        else $error("preset low did not force midscale");
    // Reload lands three to four cycles after the rise, not at once
    AST_PRESET_HOLD: assert property (!PRESET_RELOAD_PIN_N_I [*6]
        ##1 PRESET_RELOAD_PIN_N_I |-> (WIPER1_O == WIPER_MIDSCALE) [*3])
        else $error("reload came too early");
    AST_IDLE_STABLE: assert property ((CHIP_SELECT_N_I &&
        PRESET_RELOAD_PIN_N_I) [*7] |=> $stable(WIPER0_O) &&
        $stable(WIPER1_O)) else $error("wiper moved without a command");
    AST_FRAME_STABLE: assert property (PRESET_RELOAD_PIN_N_I [*7]
        ##0 !CHIP_SELECT_N_I |-> $stable(WIPER0_O) && $stable(WIPER1_O))
        else $error("wiper moved during a frame");
    AST_POWER_CAUSE: assert property (!$stable(READ_POWER_STATE_O)
        |-> CHIP_SELECT_N_I && $past(CHIP_SELECT_N_I, 3))
        else $error("read power changed without a strobe");

    cover property ($rose(CHIP_SELECT_N_I));
    cover property ($rose(READ_POWER_STATE_O));
    cover property ($rose(PRESET_RELOAD_PIN_N_I));
endmodule

bind wiper_cmd_decoder wiper_cmd_decoder_assertions u_chk (
    .CORE_CLK_I(CORE_CLK_I), .SYS_RST_I(SYS_RST_I),
    .SERIAL_CLK_I(SERIAL_CLK_I), .CHIP_SELECT_N_I(CHIP_SELECT_N_I),
    .SERIAL_INPUT_PIN_I(SERIAL_INPUT_PIN_I),
    .SERIAL_OUTPUT_PIN_O(SERIAL_OUTPUT_PIN_O),
    .SERIAL_OUTPUT_PIN_OE_O(SERIAL_OUTPUT_PIN_OE_O),
    .PRESET_RELOAD_PIN_N_I(PRESET_RELOAD_PIN_N_I),
    .WIPER0_O(WIPER0_O), .WIPER1_O(WIPER1_O),
    .READ_POWER_STATE_O(READ_POWER_STATE_O)
);
`default_nettype wire

/* File: tb/wiper_cmd_decoder_tb_top.sv */
// Self-checking bench for the dual wiper command decoder.
// Assumes the checker is bound in and the host model drives the link.
`timescale 1ns/10ps
`default_nettype none
module wiper_cmd_decoder_tb_top;
    logic       core_clk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       preset_n = 1'b1;
    logic       sclk, cs_n, mosi, ser_out, ser_out_oe, read_power;
    logic [7:0] wiper0, wiper1;
    wire        ser_out_level = ser_out_oe ? ser_out : 1'b1;  // Pull-up
    int         miscompares = 0;
    int         comparisons = 0;

    always #12.5 core_clk = ~core_clk;

    wiper_cmd_decoder u_dut (
        .CORE_CLK_I(core_clk), .SYS_RST_I(sys_rst),
        .SERIAL_CLK_I(sclk), .CHIP_SELECT_N_I(cs_n),
        .SERIAL_INPUT_PIN_I(mosi), .SERIAL_OUTPUT_PIN_O(ser_out),
        .SERIAL_OUTPUT_PIN_OE_O(ser_out_oe),
        .PRESET_RELOAD_PIN_N_I(preset_n), .WIPER0_O(wiper0),
        .WIPER1_O(wiper1), .READ_POWER_STATE_O(read_power)
    );
    host_link_model u_host (
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
        .level_i(ser_out_level)
    );

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Send one word, then compare both wipers once it has executed
    task automatic cmd(input logic [15:0] w, input logic [7:0] e0, e1);
        logic [15:0] rx;
        u_host.frame(w, rx);
        check({wiper0, wiper1}, {e0, e1});
    endtask

    // Readback word, then a full word to shift the answer out
    task automatic rd(input logic [15:0] w, input logic [15:0] exp);
        logic [15:0] rx;
        u_host.frame(w, rx);
        u_host.frame(16'h0000, rx);
        check(rx, exp);
    endtask

    task automatic do_reset();
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        #1;
        check({wiper0, wiper1}, 16'h8080);
        check({15'h0000, read_power}, 16'h0000);
        repeat (4) @(posedge core_clk);
        $display("test reset done");
    endtask

    task automatic t_steps();
        cmd(16'hb000, 8'h00, 8'h80);
        cmd(16'hb1fe, 8'h00, 8'hfe);
        cmd(16'h60ff, 8'h00, 8'hfe);
        cmd(16'he000, 8'h01, 8'hfe);
        u_host.strobe();
        check({wiper0, wiper1}, 16'h02fe);
        cmd(16'hf000, 8'h03, 8'hff);
        cmd(16'hf000, 8'h04, 8'hff);
        cmd(16'h7000, 8'h03, 8'hfe);
        cmd(16'hc0a5, 8'h06, 8'hfe);
        cmd(16'hd000, 8'h0c, 8'hff);
        cmd(16'hb000, 8'h00, 8'hff);
        cmd(16'hc000, 8'h01, 8'hff);
        cmd(16'h4100, 8'h01, 8'h7f);
        cmd(16'h5000, 8'h00, 8'h3f);
        cmd(16'h4000, 8'h00, 8'h3f);
        cmd(16'h6100, 8'h00, 8'h3e);
        cmd(16'hb180, 8'h00, 8'h80);
        cmd(16'hd000, 8'h01, 8'hff);
        cmd(16'h7000, 8'h00, 8'hfe);
        cmd(16'h0000, 8'h00, 8'hfe);
        u_host.strobe();
        check({wiper0, wiper1}, 16'h00fe);
        $display("test steps done");
    endtask

    task automatic t_readback();
        rd(16'ha100, 16'ha1fe);
        rd(16'h355a, 16'h355a);
        rd(16'h9500, 16'h955a);
        rd(16'h9f00, 16'h9f00);
        check({wiper0, wiper1}, 16'h00fe);
        $display("test readback done");
    endtask

    task automatic t_save();
        cmd(16'hb033, 8'h33, 8'hfe);
        cmd(16'h2000, 8'h33, 8'hfe);
        cmd(16'hb000, 8'h00, 8'hfe);
        cmd(16'h1000, 8'h33, 8'hfe);
        check({15'h0000, read_power}, 16'h0001);
        cmd(16'h0000, 8'h33, 8'hfe);
        check({15'h0000, read_power}, 16'h0000);
        cmd(16'hb144, 8'h33, 8'h44);
        cmd(16'h2100, 8'h33, 8'h44);
        cmd(16'hb100, 8'h33, 8'h00);
        cmd(16'hb000, 8'h00, 8'h00);
        cmd(16'h8000, 8'h33, 8'h44);
        rd(16'h9100, 16'h9144);
        $display("test save done");
    endtask

    task automatic t_preset();
        @(posedge core_clk);
        preset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        #1;
        check({wiper0, wiper1}, 16'h8080);
        @(posedge core_clk);
        preset_n <= 1'b1;
        repeat (8) @(posedge core_clk);
        #1;
        check({wiper0, wiper1}, 16'h3344);
        repeat (6) @(posedge core_clk);
        $display("test preset done");
    endtask

    task automatic conclude();
        $display("comparisons=%0d miscompares=%0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog: a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge core_clk);
        miscompares++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
        conclude();
    end

    initial begin
        do_reset();
        t_steps();
        t_readback();
        t_save();
        t_preset();
        do_reset();
        conclude();
    end
endmodule
`default_nettype wire
